// ### verilog/asu_pkg.sv
// Constants for the asynchronous serial unit: map, fields, resets, counts.
// Assumes a 32-bit register bus with byte addresses, one word per register.
package asu_pkg;
  // Register byte offsets
  localparam logic [5:0] TB_ADDR = 6'h00;
  localparam logic [5:0] RB_ADDR = 6'h04;
  localparam logic [5:0] BRG_ADDR = 6'h08;
  localparam logic [5:0] MODE_ADDR = 6'h0C;
  localparam logic [5:0] C0_ADDR = 6'h10;
  localparam logic [5:0] C1_ADDR = 6'h14;
  localparam logic [5:0] SMA_ADDR = 6'h18;
  localparam logic [5:0] SMD_ADDR = 6'h24;
  localparam logic [5:0] SHARED_SERIAL_CONTROL_ADDR = 6'h28;
  // Serial mode select codes
  localparam logic [2:0] SMD_7BIT = 3'h4;
  localparam logic [2:0] SMD_8BIT = 3'h5;
  localparam logic [2:0] SMD_9BIT = 3'h6;
  // Mode register fields
  localparam int CLKDIR_POS = 3;
  localparam int STOPS_POS = 4;
  localparam int PODD_POS = 5;
  localparam int PON_POS = 6;
  localparam int POL_POS = 7;
  // Control zero fields
  localparam int SRC_POS = 0;
  localparam int HSDIR_POS = 2;
  localparam int SREMPTY_POS = 3;
  localparam int HSDIS_POS = 4;
  localparam int ODRAIN_POS = 5;
  localparam int ORDER_POS = 7;
  // Control one fields
  localparam int TXEN_POS = 0;
  localparam int TBE_POS = 1;
  localparam int RXEN_POS = 2;
  localparam int RXC_POS = 3;
  localparam int IRS_POS = 4;
  localparam int INV_POS = 6;
  // Shared control fields
  localparam int CLKOUTB_POS = 5;
  localparam int ALTCTS_POS = 6;
  // Receive buffer error fields
  localparam int OVR_POS = 12;
  localparam int FRM_POS = 13;
  localparam int PERR_POS = 14;
  localparam int SUM_POS = 15;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [8:0] DATA_RESET = 9'h000;
  // Sixteen divider output ticks per bit
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] SUB_MID = 4'h7;
  // Prescaler terminal counts for divide by 1, 2, 8, 32
  localparam logic [4:0] PRE_F1 = 5'h00;
  localparam logic [4:0] PRE_F2 = 5'h01;
  localparam logic [4:0] PRE_F8 = 5'h07;
  localparam logic [4:0] PRE_F32 = 5'h1F;
  // Bus answers
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum {TX_IDLE, TX_SHIFT} asu_tx_e;
  typedef enum {RX_IDLE, RX_START, RX_BITS, RX_DONE} asu_rx_e;
endpackage : asu_pkg

// ### verilog/asu_baud.sv
// Baud generator: count source select, 8-bit reload divider.
// Assumes the external transfer clock pin is synchronous to clk.
`timescale 1ns/1ps
module asu_baud
  import asu_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] src_sel,
  input wire logic ext_sel,
  input wire logic ext_clk_i,
  input wire logic [7:0] reload,
  output logic tick
);
  logic [4:0] pre_reg;
  logic [4:0] pre_last;
  logic [7:0] div_reg;
  logic ext_prev_reg;
  logic src_tick;

  always_comb begin
    case (src_sel)
      2'h0: pre_last = PRE_F1;
      2'h1: pre_last = PRE_F8;
      2'h2: pre_last = PRE_F32;
      default: pre_last = PRE_F2;
    endcase
  end

  // Internal source or rising edges of the pin
  assign src_tick = ext_sel ? (ext_clk_i && !ext_prev_reg) : (pre_reg >= pre_last);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= 5'h00;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_clk_i;
      pre_reg <= (pre_reg >= pre_last) ? 5'h00 : pre_reg + 5'h01;
    end
  end

  // Divide by reload plus one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (src_tick) begin
        if (div_reg == 8'h00) begin
          div_reg <= reload;
          tick <= 1'b1;
        end else begin
          div_reg <= div_reg - 8'h01;
        end
      end
    end
  end
endmodule : asu_baud

// ### verilog/asu_uart.sv
// One channel of the asynchronous serial unit with an AXI4-Lite register slave.
// Assumes all pins are synchronous to clk; the pad logic resolves pin enables.
// Notes on behaviour
// - On overrun the buffer is undefined and no receive request is raised.
// - Framing and parity flags are set when a character enters the buffer.
// - Mode select 100b, 101b, 110b gives 7, 8 or 9 bit characters.
// - Buffers use bits 0-6, 0-7 or 0-8 per character length.
// - Transmit pin idles high, or floats when open drain, until a transfer.
// - A receive-only channel keeps the transmit pin at idle high.
// - Clock direction 0 uses internal clock; 1 takes the clock pin as input.
// - Handshake pin is a port when disabled, else clear-to-send or request-to-send.
// - Channel 0 may take clear-to-send from the shared channel-1 pin.
// - Data invert flips character bits on send and on buffer read.
// - Polarity select inverts every bit at both serial pins.
// - Two source bits pick the count source of the 8-bit reload divider.
// - Stop count and parity enable and sense are selectable.
// - A read-only flag shows the transmit shift register empty.
// - Transmit buffer empty and receive complete flags sit in control one.
// - Separate enable bits allow transmission and reception.
// - Channels 0 and 1 take transmit request source from shared control.
// - Bit rate is the source over sixteen times reload plus one.
// - Overrun is flagged at the bit before the last stop when unread.
// - Error sum is set when any overrun, framing or parity error exists.
// - Send starts only if enabled, buffer full and, when the handshake pin is clear-to-send, that pin is low.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module asu_uart
  import asu_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic serial_tx_o,
  output logic serial_tx_oe,
  input wire logic serial_rx_i,
  input wire logic transfer_clock_i,
  output logic transfer_clock_is_input,
  input wire logic handshake_i,
  output logic handshake_o,
  output logic handshake_oe,
  output logic handshake_is_port,
  input wire logic alt_handshake_i,
  input wire logic ch1_cts_selected,
  output logic tx_request,
  output logic rx_request
);
  if (CHANNEL < 0 || CHANNEL > 7) begin : g_bad
    $error("asu_uart: CHANNEL must be 0 to 7");
  end

  logic [7:0] brg_reg, mode_reg, c0_reg, c1_reg, shared_serial_control_reg;
  logic [7:0] sm_reg [4];
  logic [8:0] tb_reg, rb_reg;
  logic tb_empty_reg, ri_reg, oer_reg, fer_reg, per_reg;
  asu_tx_e tx_state;
  asu_rx_e rx_state;
  logic [12:0] tx_frame_reg;
  logic [3:0] tx_idx_reg, tx_sub_reg, tx_len_reg;
  logic tx_bit_reg;
  logic [11:0] rx_bits_reg;
  logic [3:0] rx_idx_reg, rx_sub_reg;
  logic ovr_pend_reg;
  logic bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic tick, async_on, msb8, inv, pol, par_on, par_odd, two_stop, irs;
  logic cts_in, cts_ok, tx_start, tx_last, rx_xfer, wr_en, rd_en;
  logic [3:0] nd, rx_len;
  logic [8:0] dmask, rb_view, rx_data, tb_data;
  logic [12:0] frame;
  logic rx_line, rx_par, rx_fe, txline;

  // Mode decode
  assign async_on = mode_reg[2:0] == SMD_7BIT || mode_reg[2:0] == SMD_8BIT || mode_reg[2:0] == SMD_9BIT;
  assign nd = (mode_reg[2:0] == SMD_7BIT) ? 4'h7 : (mode_reg[2:0] == SMD_9BIT) ? 4'h9 : 4'h8;
  assign dmask = (mode_reg[2:0] == SMD_7BIT) ? 9'h07F : (mode_reg[2:0] == SMD_9BIT) ? 9'h1FF : 9'h0FF;
  assign msb8 = c0_reg[ORDER_POS] && mode_reg[2:0] == SMD_8BIT;
  assign inv = c1_reg[INV_POS];
  assign pol = mode_reg[POL_POS];
  assign par_on = mode_reg[PON_POS];
  assign par_odd = mode_reg[PODD_POS];
  assign two_stop = mode_reg[STOPS_POS];
  assign irs = (CHANNEL < 2) ? shared_serial_control_reg[CHANNEL % 2] : c1_reg[IRS_POS];
  assign rx_len = nd + {3'h0, par_on} + {3'h0, two_stop} + 4'h1;

  asu_baud u_baud (
    .clk(clk),
    .arst_n(arst_n),
    .src_sel(c0_reg[SRC_POS +: 2]),
    .ext_sel(mode_reg[CLKDIR_POS]),
    .ext_clk_i(transfer_clock_i),
    .reload(brg_reg),
    .tick(tick)
  );
  assign transfer_clock_is_input = mode_reg[CLKDIR_POS];

  function automatic logic [8:0] asu_order(input logic [8:0] d, input logic rev);
    logic [8:0] r;
    r = d;
    if (rev) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7 - i];
      end
    end
    return r;
  endfunction : asu_order

  // Flow control pin
  assign cts_in = (CHANNEL == 0 && shared_serial_control_reg[ALTCTS_POS] && ch1_cts_selected && !shared_serial_control_reg[CLKOUTB_POS])
                  ? alt_handshake_i : handshake_i;
  assign cts_ok = c0_reg[HSDIS_POS] || c0_reg[HSDIR_POS] || !cts_in;
  assign handshake_is_port = c0_reg[HSDIS_POS];
  assign handshake_oe = !c0_reg[HSDIS_POS] && c0_reg[HSDIR_POS];
  assign handshake_o = !(c1_reg[RXEN_POS] && !ri_reg);

  // Transmit frame build
  assign tb_data = asu_order((tb_reg ^ (inv ? 9'h1FF : 9'h000)) & dmask, msb8);
  always_comb begin
    frame = 13'h1FFF;
    frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < nd) begin
        frame[i + 1] = tb_data[i];
      end
    end
    if (par_on) begin
      frame[nd + 4'h1] = (^tb_data) ^ par_odd;
    end
  end

  assign tx_start = tx_state == TX_IDLE && async_on && tick && c1_reg[TXEN_POS] && !tb_empty_reg && cts_ok;
  assign tx_last = tx_state == TX_SHIFT && tick && tx_sub_reg == SUB_LAST && tx_idx_reg == tx_len_reg;
  assign wr_en = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign rd_en = s_axi_arvalid && !rvalid_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state <= TX_IDLE;
      tx_frame_reg <= 13'h1FFF;
      tx_idx_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
      tx_len_reg <= 4'h0;
      tx_bit_reg <= 1'b1;
      tx_request <= 1'b0;
    end else begin
      tx_request <= 1'b0;
      if (!async_on) begin
        tx_state <= TX_IDLE;
        tx_bit_reg <= 1'b1;
      end else if (tx_start) begin
        tx_state <= TX_SHIFT;
        tx_frame_reg <= frame;
        tx_len_reg <= rx_len;
        tx_idx_reg <= 4'h0;
        tx_sub_reg <= 4'h0;
        tx_bit_reg <= 1'b0;
        tx_request <= !irs;
      end else if (tx_state == TX_SHIFT && tick) begin
        tx_sub_reg <= tx_sub_reg + 4'h1;
        if (tx_last) begin
          tx_state <= TX_IDLE;
          tx_bit_reg <= 1'b1;
          tx_request <= irs;
        end else if (tx_sub_reg == SUB_LAST) begin
          tx_idx_reg <= tx_idx_reg + 4'h1;
          tx_bit_reg <= tx_frame_reg[tx_idx_reg + 4'h1];
        end
      end
    end
  end

  // Transmit buffer and its empty flag; a write beside a load keeps the new data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tb_reg <= DATA_RESET;
      tb_empty_reg <= 1'b1;
    end else if (wr_en && s_axi_awaddr == TB_ADDR && s_axi_wstrb[0]) begin
      tb_reg <= {s_axi_wstrb[1] ? s_axi_wdata[8] : tb_reg[8], s_axi_wdata[7:0]};
      tb_empty_reg <= 1'b0;
    end else if (tx_start) begin
      tb_empty_reg <= 1'b1;
    end
  end

  // Pin drive with polarity and open drain
  assign txline = tx_bit_reg ^ pol;
  assign serial_tx_o = c0_reg[ODRAIN_POS] ? 1'b0 : txline;
  assign serial_tx_oe = async_on && (!c0_reg[ODRAIN_POS] || !txline);

  // Receiver
  assign rx_line = serial_rx_i ^ pol;
  always_comb begin
    rx_data = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (i < nd) begin
        rx_data[i] = rx_bits_reg[i];
      end
    end
    rx_data = asu_order(rx_data, msb8);
  end
  assign rx_par = rx_bits_reg[nd];
  assign rx_fe = !rx_bits_reg[nd + {3'h0, par_on}] || (two_stop && !rx_bits_reg[rx_len - 4'h1]);
  assign rx_xfer = rx_state == RX_DONE && !ovr_pend_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state <= RX_IDLE;
      rx_bits_reg <= 12'h000;
      rx_idx_reg <= 4'h0;
      rx_sub_reg <= 4'h0;
      ovr_pend_reg <= 1'b0;
    end else if (!async_on || !c1_reg[RXEN_POS]) begin
      rx_state <= RX_IDLE;
      ovr_pend_reg <= 1'b0;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_sub_reg <= 4'h0;
          ovr_pend_reg <= 1'b0;
          if (tick && !rx_line) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
            if (rx_sub_reg == SUB_MID) begin
              rx_state <= rx_line ? RX_IDLE : RX_BITS;
              rx_sub_reg <= 4'h0;
              rx_idx_reg <= 4'h0;
            end
          end
        end
        RX_BITS: begin
          if (tick) begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
            if (rx_sub_reg == SUB_LAST) begin
              rx_bits_reg[rx_idx_reg] <= rx_line;
              rx_idx_reg <= rx_idx_reg + 4'h1;
              if (rx_idx_reg == rx_len - 4'h2 && ri_reg) begin
                ovr_pend_reg <= 1'b1;
              end
              if (rx_idx_reg == rx_len - 4'h1) begin
                rx_state <= RX_DONE;
              end
            end
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // Receive buffer and flags; a transfer wins over a clearing read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rb_reg <= DATA_RESET;
      ri_reg <= 1'b0;
      oer_reg <= 1'b0;
      fer_reg <= 1'b0;
      per_reg <= 1'b0;
      rx_request <= 1'b0;
    end else begin
      rx_request <= 1'b0;
      if (!c1_reg[RXEN_POS]) begin
        ri_reg <= 1'b0;
        oer_reg <= 1'b0;
        fer_reg <= 1'b0;
        per_reg <= 1'b0;
      end else if (rx_state == RX_DONE && ovr_pend_reg) begin
        oer_reg <= 1'b1;
        if (rd_en && s_axi_araddr == RB_ADDR) begin
          ri_reg <= 1'b0;
        end
      end else if (rx_xfer) begin
        rb_reg <= rx_data;
        ri_reg <= 1'b1;
        rx_request <= 1'b1;
        oer_reg <= 1'b0;
        fer_reg <= rx_fe;
        per_reg <= par_on && (((^rx_data) ^ rx_par) != par_odd);
      end else if (rd_en && s_axi_araddr == RB_ADDR) begin
        ri_reg <= 1'b0;
      end
    end
  end
  assign rb_view = (rb_reg ^ (inv ? 9'h1FF : 9'h000)) & dmask;

  // Configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      brg_reg <= REG_RESET;
      mode_reg <= REG_RESET;
      c0_reg <= REG_RESET;
      c1_reg <= REG_RESET;
      shared_serial_control_reg <= REG_RESET;
      for (int i = 0; i < 4; i++) begin
        sm_reg[i] <= REG_RESET;
      end
    end else if (wr_en && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == BRG_ADDR) begin
        brg_reg <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == MODE_ADDR) begin
        mode_reg <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == C0_ADDR) begin
        c0_reg <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == C1_ADDR) begin
        c1_reg <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == SHARED_SERIAL_CONTROL_ADDR) begin
        shared_serial_control_reg <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr >= SMA_ADDR && s_axi_awaddr <= SMD_ADDR && s_axi_awaddr[1:0] == 2'h0) begin
        sm_reg[s_axi_awaddr[3:2] - 2'h2] <= s_axi_wdata[7:0];
      end
    end
  end

  // Write answer
  assign s_axi_awready = wr_en;
  assign s_axi_wready = wr_en;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OK;
    end else if (wr_en) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (s_axi_awaddr > SHARED_SERIAL_CONTROL_ADDR || s_axi_awaddr == RB_ADDR || s_axi_awaddr[1:0] != 2'h0)
                   ? RESP_ERR : RESP_OK;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Read answer; write-only registers read as zero
  assign s_axi_arready = rd_en;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OK;
    end else if (rd_en) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OK;
      rdata_reg <= 32'h0000_0000;
      if (s_axi_araddr == RB_ADDR) begin
        rdata_reg[8:0] <= rb_view;
        rdata_reg[OVR_POS] <= oer_reg;
        rdata_reg[FRM_POS] <= fer_reg;
        rdata_reg[PERR_POS] <= per_reg;
        rdata_reg[SUM_POS] <= oer_reg || fer_reg || per_reg;
      end else if (s_axi_araddr == MODE_ADDR) begin
        rdata_reg[7:0] <= mode_reg;
      end else if (s_axi_araddr == C0_ADDR) begin
        rdata_reg[7:0] <= c0_reg;
        rdata_reg[SREMPTY_POS] <= tx_state == TX_IDLE;
      end else if (s_axi_araddr == C1_ADDR) begin
        rdata_reg[7:0] <= c1_reg;
        rdata_reg[TBE_POS] <= tb_empty_reg;
        rdata_reg[RXC_POS] <= ri_reg;
      end else if (s_axi_araddr == SHARED_SERIAL_CONTROL_ADDR) begin
        rdata_reg[7:0] <= shared_serial_control_reg;
      end else if (s_axi_araddr >= SMA_ADDR && s_axi_araddr <= SMD_ADDR && s_axi_araddr[1:0] == 2'h0) begin
        rdata_reg[7:0] <= sm_reg[s_axi_araddr[3:2] - 2'h2];
      end else if (s_axi_araddr != TB_ADDR && s_axi_araddr != BRG_ADDR) begin
        rresp_reg <= RESP_ERR;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  ovr_no_req_a: assert property ((rx_state == RX_DONE && ovr_pend_reg && c1_reg[RXEN_POS])
    |=> !rx_request && oer_reg) else $error("overrun raised a receive request");
  flag_at_xfer_a: assert property ($rose(fer_reg) |-> $past(rx_xfer))
    else $error("framing flag set outside a transfer");
  idle_high_a: assert property (tx_state == TX_IDLE |-> tx_bit_reg)
    else $error("transmit line not idle high");
  start_low_a: assert property (tx_start |=> !tx_bit_reg && tx_state == TX_SHIFT ##1 !tx_bit_reg)
    else $error("start bit not low");
  tx_cond_a: assert property (tx_start |-> c1_reg[TXEN_POS] && !tb_empty_reg && cts_ok
    ##1 tb_empty_reg || $past(wr_en)) else $error("transmit started without its conditions");
  ovr_cause_a: assert property ($rose(ovr_pend_reg) |-> $past(ri_reg))
    else $error("overrun without unread character");
  rx_width_a: assert property (rx_request && mode_reg[2:0] != SMD_9BIT |-> !rb_reg[8])
    else $error("receive data above character width");
  hs_pin_a: assert property (c0_reg[HSDIS_POS] |-> !handshake_oe && handshake_is_port)
    else $error("handshake pin driven while a port");
endmodule : asu_uart

// ### bench/asu_peer.sv
// Remote serial peer: drives the receive line, samples the transmit line.
// Assumes 16 clk cycles per bit (reload 0, divide by 1).
`timescale 1ns/1ps
module asu_peer (
  input wire logic clk,
  input wire logic tx_i,
  output logic rx_o
);
  initial rx_o = 1'b1;
  task automatic idle(input logic lvl);
    @(posedge clk);
    rx_o <= lvl;
  endtask : idle
  // Start bit first, each bit held 16 cycles
  task automatic snd(input logic [13:0] f, input int len, input logic lvl);
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      rx_o <= f[i];
      repeat (15) @(posedge clk);
    end
    @(posedge clk);
    rx_o <= lvl;
  endtask : snd
  // Mid-bit sampling from the leading edge of the start bit
  task automatic cap(input logic lvl, input int len, output logic [13:0] f);
    int n;
    n = 0;
    f = '0;
    while (tx_i === lvl && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    for (int i = 0; i < len; i++) begin
      f[i] = tx_i;
      repeat (16) @(posedge clk);
    end
  endtask : cap
endmodule : asu_peer

// ### bench/tb_top.sv
// Bench for one serial channel: bus master, serial peer, frame checks.
// Assumes reload 0 and divide by 1, so each bit lasts 16 clk cycles.
`timescale 1ns/1ps
module tb_top;
  import asu_pkg::*;
  typedef struct {logic [7:0] m; logic [7:0] c0; logic [7:0] c1; logic [8:0] d;} asu_row_s;
  logic clk, arst_n, awv, awr, wv, bv, br, arv, arr, rv, rr;
  logic [5:0] awa, ara;
  logic [31:0] wd, rdt, d;
  logic [1:0] bresp, rresp, rs;
  logic txo, txoe, rxl, hs_n, hsp, hsoe, tci, txq, rxq, hso, alt_hs, ch1s;
  logic [13:0] f, g, dm;
  int err_count = 0, n_compared = 0, tx_cnt = 0, rx_cnt = 0, len, c, n;
  asu_row_s r;
  asu_row_s rows [8] = '{
    '{8'h05, 8'h10, 8'h05, 9'h0A3}, '{8'h04, 8'h10, 8'h05, 9'h055}, '{8'h05, 8'h90, 8'h05, 9'h0A3},
    '{8'h06, 8'h10, 8'h05, 9'h1A5}, '{8'h55, 8'h10, 8'h05, 9'h03C}, '{8'h65, 8'h10, 8'h05, 9'h03C},
    '{8'h05, 8'h04, 8'h45, 9'h00F}, '{8'h85, 8'h10, 8'h05, 9'h081}};
  asu_uart asu_uart_inst (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .serial_tx_o(txo), .serial_tx_oe(txoe), .serial_rx_i(rxl), .transfer_clock_i(1'b0),
    .transfer_clock_is_input(tci), .handshake_i(hs_n), .handshake_o(hso), .handshake_oe(hsoe),
    .handshake_is_port(hsp), .alt_handshake_i(alt_hs), .ch1_cts_selected(ch1s), .tx_request(txq),
    .rx_request(rxq));
  // Released transmit pin reads as the pull-up level
  asu_peer asu_peer_inst (.clk(clk), .tx_i(txoe ? txo : 1'b1), .rx_o(rxl));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (txq === 1'b1) tx_cnt <= tx_cnt + 1;
    if (rxq === 1'b1) rx_cnt <= rx_cnt + 1;
  end
  task automatic print_verdict;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Looks at negedges until s is high; the caller then takes the next posedge
  task automatic until_hi(ref logic s);
    int k;
    k = 0;
    @(negedge clk);
    while (s !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    if (k >= 50) err_count++;
  endtask : until_hi
  task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] e = RESP_OK);
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    until_hi(awr);
    @(posedge clk);
    awv <= 1'b0;
    wv <= 1'b0;
    until_hi(bv);
    chk(32'(bresp), 32'(e));
    @(posedge clk);
    br <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] q);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    until_hi(arr);
    @(posedge clk);
    arv <= 1'b0;
    until_hi(rv);
    v = rdt;
    q = rresp;
    @(posedge clk);
    rr <= 1'b0;
  endtask : rd
  // Disable first so a change of line level is not taken as a start bit
  task automatic cfg(input asu_row_s x);
    wr(C1_ADDR, 32'h0);
    asu_peer_inst.idle(~x.m[POL_POS]);
    wr(MODE_ADDR, 32'(x.m));
    wr(C0_ADDR, 32'(x.c0));
    wr(C1_ADDR, 32'(x.c1));
  endtask : cfg
  task automatic rxone(input logic [13:0] fr, input int ln, input logic lvl);
    c = rx_cnt;
    asu_peer_inst.snd(fr, ln, lvl);
    n = 0;
    while (rx_cnt == c && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(32'(rx_cnt - c), 32'h1);
    rd(RB_ADDR, d, rs);
  endtask : rxone
  // Pin-level frame with start at bit 0
  function automatic logic [13:0] mkframe(input asu_row_s x, output int ln, output logic [13:0] m);
    logic [13:0] fr;
    logic [8:0] v;
    int nb;
    nb = (x.m[2:0] == SMD_7BIT) ? 7 : (x.m[2:0] == SMD_9BIT) ? 9 : 8;
    m = 14'((1 << nb) - 1);
    v = (x.c1[INV_POS] ? ~x.d : x.d) & 9'(m);
    fr = '0;
    for (int i = 0; i < nb; i++) fr[i + 1] = (nb == 8 && x.c0[ORDER_POS]) ? v[7 - i] : v[i];
    ln = nb + 1;
    fr[ln] = ^v ^ x.m[PODD_POS];
    ln = ln + int'(x.m[PON_POS]);
    fr[ln] = 1'b1;
    fr[ln + 1] = 1'b1;
    ln = ln + 1 + int'(x.m[STOPS_POS]);
    return x.m[POL_POS] ? ~fr : fr;
  endfunction : mkframe
  initial begin
    #200000;
    err_count++;
    print_verdict;
  end
  initial begin
    arst_n = 1'b0;
    awa = '0;
    ara = '0;
    wd = '0;
    awv = 1'b0;
    wv = 1'b0;
    br = 1'b0;
    arv = 1'b0;
    rr = 1'b0;
    hs_n = 1'b0;
    alt_hs = 1'b1;
    ch1s = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rd(C1_ADDR, d, rs);
    chk(d, 32'h2);
    rd(6'h2C, d, rs);
    chk(32'(rs), 32'(RESP_ERR));
    chk(d, 32'h0);
    wr(RB_ADDR, 32'h1, RESP_ERR);
    foreach (rows[i]) begin
      r = rows[i];
      cfg(r);
      @(negedge clk);
      chk(32'({txoe, txo, hsp, hsoe, tci, hso}), 32'({1'b1, ~r.m[POL_POS], r.c0[HSDIS_POS],
        ~r.c0[HSDIS_POS] & r.c0[HSDIR_POS], r.m[CLKDIR_POS], 1'b0}));
      f = mkframe(r, len, dm);
      fork
        asu_peer_inst.cap(~r.m[POL_POS], len, g);
        wr(TB_ADDR, 32'(r.d));
      join
      chk(32'(g), 32'(f & ((14'h1 << len) - 14'h1)));
      rxone(f, len, ~r.m[POL_POS]);
      chk(d, 32'(r.d & 9'(dm)));
    end
    r = '{8'h05, 8'h10, 8'h05, 9'h05A};
    cfg(r);
    f = mkframe(r, len, dm);
    c = rx_cnt;
    asu_peer_inst.snd(f, len, 1'b1);
    asu_peer_inst.snd(f, len, 1'b1);
    repeat (20) @(posedge clk);
    chk(32'(rx_cnt - c), 32'h1);
    chk(32'(hso), 32'h1);
    rd(RB_ADDR, d, rs);
    chk(d & 32'hF000, 32'h9000);
    cfg(r);
    f[9] = 1'b0;
    rxone(f, len, 1'b1);
    chk(d, 32'hA05A);
    r.m = 8'h45;
    cfg(r);
    f = mkframe(r, len, dm);
    f[9] = ~f[9];
    rxone(f, len, 1'b1);
    chk(d, 32'hC05A);
    hs_n <= 1'b1;
    r = '{8'h05, 8'h00, 8'h05, 9'h033};
    cfg(r);
    wr(TB_ADDR, 32'h33);
    repeat (100) @(posedge clk);
    chk(32'(txo), 32'h1);
    rd(C1_ADDR, d, rs);
    chk(d, 32'h05);
    rd(C0_ADDR, d, rs);
    chk(d, 32'h08);
    f = mkframe(r, len, dm);
    fork
      asu_peer_inst.cap(1'b1, len, g);
      hs_n <= 1'b0;
    join
    chk(32'(g), 32'(f & ((14'h1 << len) - 14'h1)));
    rd(C1_ADDR, d, rs);
    chk(d, 32'h07);
    // Channel 0 takes clear-to-send from the shared pin, request at end of frame
    ch1s <= 1'b1;
    wr(SHARED_SERIAL_CONTROL_ADDR, 32'h41);
    wr(TB_ADDR, 32'h33);
    repeat (100) @(posedge clk);
    rd(C1_ADDR, d, rs);
    chk(d, 32'h05);
    fork
      asu_peer_inst.cap(1'b1, len, g);
      alt_hs <= 1'b0;
    join
    chk(32'(g), 32'(f & ((14'h1 << len) - 14'h1)));
    // Reload 1 doubles the bit time
    wr(BRG_ADDR, 32'h1);
    wr(TB_ADDR, 32'h33);
    repeat (200) @(posedge clk);
    rd(C0_ADDR, d, rs);
    chk(d, 32'h00);
    repeat (200) @(posedge clk);
    rd(C0_ADDR, d, rs);
    chk(d, 32'h08);
    chk(32'(tx_cnt), 32'hB);
    print_verdict;
  end
endmodule : tb_top
